// ### design/sac_sequencer.v
// Register access over APB is this design's own decision.
`default_nettype none

module sac_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire        comparator_in,
  input  wire        internal_rc_clock,
  output reg  [1:0]  front_channel,
  output reg         front_ref_external,
  output reg         front_power,
  output reg         front_sample,
  output reg  [9:0]  front_dac_code,
  output reg  [3:0]  pin_digital_in_en,
  output reg  [5:0]  pin_out_en
);

`include "sac_defs.vh"

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_CONV  = 2'b01;
  localparam [1:0] ST_ABORT = 2'b10;

  reg  [7:0]  interrupt_control;
  reg  [7:0]  peripheral_irq_flags;
  reg  [7:0]  peripheral_irq_enables;
  reg  [7:0]  converter_control_reg;
  reg  [7:0]  analog_select_reg;
  reg  [5:0]  pin_tristate;
  reg  [9:0]  result_high_low;
  reg  [1:0]  state;
  reg  [3:0]  tad_cnt;
  reg  [9:0]  sar_code;
  reg  [9:0]  sar_mask;
  reg         comp_s1;
  reg         comp_s2;
  reg         comp_s3;
  reg         comp_level;
  reg  [31:0] next_prdata;
  reg         next_slverr;
  reg  [9:0]  next_sar;
  reg  [7:0]  result_high;
  reg  [7:0]  result_low;
  wire [9:0]  reg_idx;
  wire        access;
  wire        wr;
  wire        wr_ctl;
  wire        go;
  wire        conv_on;
  wire        start;
  wire        abort;
  wire        tad_tick;
  wire        last_tad;
  wire        done_evt;
  wire        tad_restart;
  wire        irq_cause;

  assign reg_idx  = paddr[11:2];
  assign access   = psel & penable;
  // Writes land only on the edge that completes the access
  assign wr       = access & pready & pwrite;
  assign wr_ctl   = wr & (reg_idx == `SAC_IDX_CONVCTL);
  assign go       = converter_control_reg[`SAC_BIT_GO];
  assign conv_on  = converter_control_reg[`SAC_BIT_ENABLE];
  assign start    = (state == ST_IDLE) & go & conv_on;
  assign abort    = (state == ST_CONV) & ~go;
  assign last_tad = tad_tick & (tad_cnt == `SAC_CONV_TADS - 4'h1);
  assign done_evt = (state == ST_CONV) & go & last_tad;
  // Abort restarts the divider too, so the wait before acquiring is two whole periods
  assign tad_restart = start | abort;
  assign irq_cause = peripheral_irq_flags[`SAC_BIT_DONE] & peripheral_irq_enables[`SAC_BIT_DONE]
                   & interrupt_control[`SAC_BIT_GATE] & interrupt_control[`SAC_BIT_GLOBAL];

  sac_tad_gen u_tad_gen (
    .pclk              (pclk),
    .presetn           (presetn),
    .conv_clock_select (analog_select_reg[`SAC_ADCS_HI:`SAC_ADCS_LO]),
    .restart           (tad_restart),
    .internal_rc_clock (internal_rc_clock),
    .tad_tick          (tad_tick)
  );

  // Comparator output is asynchronous to pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_s1    <= 1'b0;
      comp_s2    <= 1'b0;
      comp_s3    <= 1'b0;
      comp_level <= 1'b0;
    end else begin
      comp_s1    <= comparator_in;
      comp_s2    <= comp_s1;
      comp_s3    <= comp_s2;
      comp_level <= (comp_s2 == comp_s3) ? comp_s3 : comp_level;
    end
  end

  // One trial bit resolved per period: keep it if the input sits above the trial level
  always @* begin
    next_sar = sar_code;
    if (!comp_level) begin
      next_sar = sar_code & ~sar_mask;
    end
    next_sar = next_sar | (sar_mask >> 1);
  end

  // Result kept raw; flipping justify reformats the last result on the next read
  always @* begin
    if (converter_control_reg[`SAC_BIT_JUSTIFY]) begin
      result_high = {6'h00, result_high_low[9:8]};
      result_low  = result_high_low[7:0];
    end else begin
      result_high = result_high_low[9:2];
      result_low  = {result_high_low[1:0], 6'h00};
    end
  end

  // Tick zero resolves no bit; the next ten ticks resolve one bit each, MSB first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= ST_IDLE;
      tad_cnt         <= 4'h0;
      sar_code        <= `SAC_RST_RESULT;
      sar_mask        <= `SAC_RST_RESULT;
      result_high_low <= `SAC_RST_RESULT;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state    <= ST_CONV;
            tad_cnt  <= 4'h0;
            sar_code <= `SAC_SAR_MSB;
            sar_mask <= `SAC_SAR_MSB;
          end
        end
        ST_CONV: begin
          if (abort) begin
            // Partial code is dropped; result keeps the earlier conversion
            state   <= ST_ABORT;
            tad_cnt <= 4'h0;
          end else if (tad_tick) begin
            tad_cnt <= tad_cnt + 4'h1;
            if (tad_cnt != 4'h0) begin
              sar_code <= next_sar;
              sar_mask <= sar_mask >> 1;
            end
            if (last_tad) begin
              result_high_low <= next_sar;
              state           <= ST_IDLE;
            end
          end
        end
        ST_ABORT: begin
          if (tad_tick) begin
            tad_cnt <= tad_cnt + 4'h1;
            if (tad_cnt == `SAC_ABORT_TADS - 4'h1) begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_control_reg <= `SAC_RST_CONVCTL;
    end else begin
      // Unused bits 5:4 stay zero
      if (wr_ctl) begin
        converter_control_reg[`SAC_BIT_JUSTIFY] <= pwdata[`SAC_BIT_JUSTIFY];
        converter_control_reg[`SAC_BIT_REF]     <= pwdata[`SAC_BIT_REF];
        converter_control_reg[`SAC_CHS_HI:`SAC_CHS_LO] <= pwdata[`SAC_CHS_HI:`SAC_CHS_LO];
        converter_control_reg[`SAC_BIT_ENABLE] <= pwdata[`SAC_BIT_ENABLE];
      end
      // Go only counts while the converter was already on before this write
      if (done_evt) begin
        converter_control_reg[`SAC_BIT_GO] <= 1'b0;
      end else if (wr_ctl) begin
        converter_control_reg[`SAC_BIT_GO] <= pwdata[`SAC_BIT_GO] & conv_on & pwdata[`SAC_BIT_ENABLE];
      end else if (!conv_on) begin
        converter_control_reg[`SAC_BIT_GO] <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control      <= `SAC_RST_INTCTL;
      peripheral_irq_flags   <= `SAC_RST_FLAGS;
      peripheral_irq_enables <= `SAC_RST_ENABLES;
      analog_select_reg      <= `SAC_RST_ANASEL;
      pin_tristate           <= `SAC_RST_TRIS;
    end else begin
      if (wr && reg_idx == `SAC_IDX_INTCTL) begin
        interrupt_control[`SAC_BIT_GLOBAL] <= pwdata[`SAC_BIT_GLOBAL];
        interrupt_control[`SAC_BIT_GATE]   <= pwdata[`SAC_BIT_GATE];
      end
      if (wr && reg_idx == `SAC_IDX_ENABLES) begin
        peripheral_irq_enables[`SAC_BIT_DONE] <= pwdata[`SAC_BIT_DONE];
      end
      if (wr && reg_idx == `SAC_IDX_ANASEL) begin
        analog_select_reg[`SAC_ADCS_HI:`SAC_ANS_LO] <= pwdata[`SAC_ADCS_HI:`SAC_ANS_LO];
      end
      if (wr && reg_idx == `SAC_IDX_TRIS) begin
        pin_tristate <= pwdata[5:0];
      end
      // Completion wins over a write-one clear in the same cycle
      if (done_evt) begin
        peripheral_irq_flags[`SAC_BIT_DONE] <= 1'b1;
      end else if (wr && reg_idx == `SAC_IDX_FLAGS && pwdata[`SAC_BIT_DONE]) begin
        peripheral_irq_flags[`SAC_BIT_DONE] <= 1'b0;
      end
    end
  end

  // Unmapped indices answer with an error and read as zero
  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (reg_idx)
      `SAC_IDX_INTCTL:  next_prdata[7:0] = interrupt_control;
      `SAC_IDX_FLAGS:   next_prdata[7:0] = peripheral_irq_flags;
      `SAC_IDX_ENABLES: next_prdata[7:0] = peripheral_irq_enables;
      `SAC_IDX_CONVCTL: next_prdata[7:0] = converter_control_reg;
      `SAC_IDX_ANASEL:  next_prdata[7:0] = analog_select_reg;
      `SAC_IDX_TRIS:    next_prdata[5:0] = pin_tristate;
      `SAC_IDX_RESHI:   next_prdata[7:0] = result_high;
      `SAC_IDX_RESLO:   next_prdata[7:0] = result_low;
      default:          next_slverr      = 1'b1;
    endcase
  end

  // One wait state: pready rises in the second access cycle, data registered with it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & next_slverr;
      if (access && !pready && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq                <= 1'b0;
      front_channel      <= 2'b00;
      front_ref_external <= 1'b0;
      front_power        <= 1'b0;
      front_sample       <= 1'b0;
      front_dac_code     <= `SAC_RST_RESULT;
      pin_digital_in_en  <= 4'h0;
      pin_out_en         <= 6'h00;
    end else begin
      irq                <= irq_cause;
      front_channel      <= converter_control_reg[`SAC_CHS_HI:`SAC_CHS_LO];
      front_ref_external <= converter_control_reg[`SAC_BIT_REF];
      front_power        <= conv_on;
      // Hold tracks the input whenever powered and not converting or in the abort gap
      front_sample       <= conv_on & (state == ST_IDLE);
      front_dac_code     <= sar_code;
      // Inverted so reset leaves every pin analog with its driver off
      pin_digital_in_en  <= ~analog_select_reg[`SAC_ANS_HI:`SAC_ANS_LO];
      pin_out_en         <= ~pin_tristate;
    end
  end

endmodule

`default_nettype wire

// ### design/sac_defs.vh
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH

// Register indices; byte address is four times the index
`define SAC_IDX_INTCTL   10'h00b
`define SAC_IDX_FLAGS    10'h00c
`define SAC_IDX_ENABLES  10'h08c
`define SAC_IDX_CONVCTL  10'h01f
`define SAC_IDX_ANASEL   10'h09f
`define SAC_IDX_TRIS     10'h085
`define SAC_IDX_RESHI    10'h020
`define SAC_IDX_RESLO    10'h021

// Reset values
`define SAC_RST_INTCTL   8'h00
`define SAC_RST_FLAGS    8'h00
`define SAC_RST_ENABLES  8'h00
`define SAC_RST_CONVCTL  8'h00
`define SAC_RST_ANASEL   8'h0f
`define SAC_RST_TRIS     6'h3f
`define SAC_RST_RESULT   10'h000

// Field positions
`define SAC_BIT_GLOBAL   7
`define SAC_BIT_GATE     6
`define SAC_BIT_DONE     6
`define SAC_BIT_JUSTIFY  7
`define SAC_BIT_REF      6
`define SAC_CHS_HI       3
`define SAC_CHS_LO       2
`define SAC_BIT_GO       1
`define SAC_BIT_ENABLE   0
`define SAC_ADCS_HI      6
`define SAC_ADCS_LO      4
`define SAC_ANS_HI       3
`define SAC_ANS_LO       0

// Conversion clock select codes and matching divide-minus-one
`define SAC_CS_DIV2      3'b000
`define SAC_CS_DIV4      3'b100
`define SAC_CS_DIV8      3'b001
`define SAC_CS_DIV16     3'b101
`define SAC_CS_DIV32     3'b010
`define SAC_CS_DIV64     3'b110
`define SAC_CS_RC_LOW    2'b11
`define SAC_DM1_2        6'h01
`define SAC_DM1_4        6'h03
`define SAC_DM1_8        6'h07
`define SAC_DM1_16       6'h0f
`define SAC_DM1_32       6'h1f
`define SAC_DM1_64       6'h3f

// Sequence timing in conversion clock periods, and the first SAR trial code
`define SAC_CONV_TADS    4'hb
`define SAC_ABORT_TADS   4'h2
`define SAC_SAR_MSB      10'h200

`endif

// ### design/sac_tad_gen.v
`default_nettype none

module sac_tad_gen (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [2:0] conv_clock_select,
  input  wire       restart,
  input  wire       internal_rc_clock,
  output reg        tad_tick
);

`include "sac_defs.vh"

  reg [5:0] div_cnt;
  reg [5:0] div_m1;
  reg       rc_s1;
  reg       rc_s2;
  reg       rc_s3;
  reg       rc_level;
  reg       rc_level_d;
  wire      use_rc;
  wire      div_hit;

  assign use_rc  = (conv_clock_select[1:0] == `SAC_CS_RC_LOW);
  assign div_hit = (div_cnt == div_m1);

  always @* begin
    case (conv_clock_select)
      `SAC_CS_DIV2:  div_m1 = `SAC_DM1_2;
      `SAC_CS_DIV4:  div_m1 = `SAC_DM1_4;
      `SAC_CS_DIV8:  div_m1 = `SAC_DM1_8;
      `SAC_CS_DIV16: div_m1 = `SAC_DM1_16;
      `SAC_CS_DIV32: div_m1 = `SAC_DM1_32;
      `SAC_CS_DIV64: div_m1 = `SAC_DM1_64;
      default:       div_m1 = `SAC_DM1_2;
    endcase
  end

  // RC clock is asynchronous; a level counts only once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_s1      <= 1'b0;
      rc_s2      <= 1'b0;
      rc_s3      <= 1'b0;
      rc_level   <= 1'b0;
      rc_level_d <= 1'b0;
    end else begin
      rc_s1      <= internal_rc_clock;
      rc_s2      <= rc_s1;
      rc_s3      <= rc_s2;
      rc_level   <= (rc_s2 == rc_s3) ? rc_s3 : rc_level;
      rc_level_d <= rc_level;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt  <= 6'h00;
      tad_tick <= 1'b0;
    end else if (restart) begin
      div_cnt  <= 6'h00;
      tad_tick <= 1'b0;
    end else if (use_rc) begin
      div_cnt  <= 6'h00;
      tad_tick <= rc_level & ~rc_level_d;
    end else begin
      div_cnt  <= div_hit ? 6'h00 : div_cnt + 6'h01;
      tad_tick <= div_hit;
    end
  end

endmodule

`default_nettype wire

// ### verification/sac_seq_props.sv
`default_nettype none
module sac_seq_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        front_power,
  input wire logic        front_sample,
  input wire logic [1:0]  front_channel,
  input wire logic        front_ref_external,
  input wire logic [3:0]  pin_digital_in_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_done;
  assign wr_done = pready && pwrite;
  chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_sample_power: assert property (front_sample |-> front_power)
    else $error("tracking while unpowered");
  chk_conv_length: assert property ($fell(front_sample) && front_power |-> !front_sample [*6])
    else $error("conversion ended too soon");
  chk_chan_write: assert property (!$stable(front_channel) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("channel moved without write");
  chk_ref_write: assert property (!$stable(front_ref_external) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("reference moved without write");
  chk_pin_write: assert property (!$stable(pin_digital_in_en) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("pin buffers moved without write");
  cover property ($fell(front_sample));
  cover property (pslverr);
  cover property ($rose(front_ref_external));
endmodule

bind sac_sequencer sac_seq_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata), .front_power(front_power),
  .front_sample(front_sample), .front_channel(front_channel), .front_ref_external(front_ref_external),
  .pin_digital_in_en(pin_digital_in_en));
`default_nettype wire

// ### verification/sac_afe_model.sv
`default_nettype none
module sac_afe_model (
  input  wire logic            pclk,
  input  wire logic [3:0][9:0] level,
  input  wire logic [1:0]      front_channel,
  input  wire logic            front_ref_external,
  input  wire logic            front_power,
  input  wire logic            front_sample,
  input  wire logic [9:0]      front_dac_code,
  output var  logic            comparator_in,
  output var  logic            internal_rc_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held = 10'h000;
  initial comparator_in = 1'b0;
  initial internal_rc_clock = 1'b0;
  // Dedicated oscillator runs free, unrelated to pclk
  always #20 internal_rc_clock = ~internal_rc_clock;
  always @(posedge pclk) begin
    // External reference modelled at twice the supply
    if (front_sample) begin
      held <= front_ref_external ? level[front_channel] >> 1 : level[front_channel];
    end
    // Unpowered comparator gives garbage, never a steady answer
    comparator_in <= front_power ? held >= front_dac_code : ~comparator_in;
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
`default_nettype none
`include "sac_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata, rd;
  logic            pready, pslverr, irq, cmp, rc, err;
  logic            front_ref_external, front_power, front_sample;
  logic [1:0]      front_channel;
  logic [9:0]      front_dac_code, r;
  logic [3:0]      pin_digital_in_en;
  logic [5:0]      pin_out_en;
  logic [7:0]      ctl;
  logic [3:0][9:0] level = {10'h2c5, 10'h13a, 10'h3ff, 10'h001};
  logic [9:0]      ri [8] = '{`SAC_IDX_INTCTL, `SAC_IDX_FLAGS, `SAC_IDX_ENABLES, `SAC_IDX_CONVCTL,
                              `SAC_IDX_ANASEL, `SAC_IDX_TRIS, `SAC_IDX_RESHI, `SAC_IDX_RESLO};
  logic [7:0]      rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h3f, 8'h00, 8'h00};
  logic [2:0]      cs [4] = '{`SAC_CS_DIV8, `SAC_CS_DIV16, `SAC_CS_DIV32, `SAC_CS_DIV64};
  int              num_errors = 0;
  int              compares = 0;
  int              c;
  always #2 pclk = ~pclk;
  sac_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .comparator_in(cmp), .internal_rc_clock(rc), .front_channel(front_channel),
    .front_ref_external(front_ref_external), .front_power(front_power), .front_sample(front_sample),
    .front_dac_code(front_dac_code), .pin_digital_in_en(pin_digital_in_en), .pin_out_en(pin_out_en));
  sac_afe_model afe (.pclk(pclk), .level(level), .front_channel(front_channel),
    .front_ref_external(front_ref_external), .front_power(front_power), .front_sample(front_sample),
    .front_dac_code(front_dac_code), .comparator_in(cmp), .internal_rc_clock(rc));
  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic fail(input string what);
    num_errors++;
    $display("ERROR %s expected done seen timeout", what);
    finish_test();
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) fail("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input string what, input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(what, {24'h0, exp}, rd);
  endtask
  task automatic wait_irq();
    c = 0;
    while (irq !== 1'b1 && c < 3000) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 3000) fail("irq");
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("pins after reset", 32'h0, {22'h0, pin_out_en, pin_digital_in_en});
    for (int i = 0; i < 8; i++) rdchk("reset value", ri[i], rv[i]);
    apb(1'b1, 10'h3ff, 8'hff);
    apb(1'b0, 10'h3ff, 8'h00);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    apb(1'b1, `SAC_IDX_ANASEL, 8'h95);
    apb(1'b1, `SAC_IDX_TRIS, 8'h0a);
    repeat (2) @(posedge pclk);
    check("pins", 32'h35a, {22'h0, pin_out_en, pin_digital_in_en});
    rdchk("analog select", `SAC_IDX_ANASEL, 8'h15);
    apb(1'b1, `SAC_IDX_CONVCTL, 8'h03);
    repeat (120) @(posedge pclk);
    rdchk("go ignored", `SAC_IDX_CONVCTL, 8'h01);
    rdchk("no flag", `SAC_IDX_FLAGS, 8'h00);
    $display("test setup done");
    apb(1'b1, `SAC_IDX_ENABLES, 8'h40);
    apb(1'b1, `SAC_IDX_INTCTL, 8'hc0);
    // Divide 2 and 4 outrun the comparator path, so only slow clocks are used
    for (int i = 0; i < 4; i++) begin
      ctl = {i[0], i[1], 2'b00, i[1:0], 2'b01};
      r = i[1] ? level[i] >> 1 : level[i];
      apb(1'b1, `SAC_IDX_ANASEL, {1'b0, cs[i], 4'h5});
      apb(1'b1, `SAC_IDX_CONVCTL, ctl);
      apb(1'b1, `SAC_IDX_CONVCTL, ctl | 8'h02);
      wait_irq();
      check("conv time", 32'h1, {31'h0, c >= (11 << (i + 3)) - 2 && c <= (11 << (i + 3)) + 6});
      rdchk("result high", `SAC_IDX_RESHI, i[0] ? {6'h0, r[9:8]} : r[9:2]);
      rdchk("result low", `SAC_IDX_RESLO, i[0] ? r[7:0] : {r[1:0], 6'h0});
      rdchk("go cleared", `SAC_IDX_CONVCTL, ctl);
      rdchk("flag set", `SAC_IDX_FLAGS, 8'h40);
      apb(1'b1, `SAC_IDX_FLAGS, 8'h40);
      repeat (2) @(posedge pclk);
      check("irq cleared", 32'h0, {31'h0, irq});
      $display("test divide %0d done", 8 << i);
    end
    // Fast divides prove the period count only; the comparator path cannot follow them
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `SAC_IDX_ANASEL, {1'b0, (i[0] ? `SAC_CS_DIV4 : `SAC_CS_DIV2), 4'h5});
      apb(1'b1, `SAC_IDX_CONVCTL, 8'h03);
      wait_irq();
      check("fast conv time", 32'h1, {31'h0, c >= (22 << i) - 2 && c <= (22 << i) + 6});
      apb(1'b1, `SAC_IDX_FLAGS, 8'h40);
    end
    $display("test fast divide done");
    apb(1'b1, `SAC_IDX_INTCTL, 8'h80);
    apb(1'b1, `SAC_IDX_ANASEL, 8'h15);
    apb(1'b1, `SAC_IDX_CONVCTL, 8'h03);
    repeat (108) @(posedge pclk);
    check("irq gated", 32'h0, {31'h0, irq});
    rdchk("gated flag", `SAC_IDX_FLAGS, 8'h40);
    apb(1'b1, `SAC_IDX_INTCTL, 8'hc0);
    repeat (2) @(posedge pclk);
    check("irq ungated", 32'h1, {31'h0, irq});
    apb(1'b1, `SAC_IDX_FLAGS, 8'h40);
    $display("test mask done");
    // No sleep in this bench; the RC clock is used awake only to reach its code
    apb(1'b1, `SAC_IDX_ANASEL, 8'h35);
    apb(1'b1, `SAC_IDX_CONVCTL, 8'h8b);
    wait_irq();
    rdchk("rc high", `SAC_IDX_RESHI, 8'h01);
    rdchk("rc low", `SAC_IDX_RESLO, 8'h3a);
    apb(1'b1, `SAC_IDX_FLAGS, 8'h40);
    apb(1'b1, `SAC_IDX_ANASEL, 8'h15);
    apb(1'b1, `SAC_IDX_CONVCTL, 8'h87);
    repeat (20) @(posedge pclk);
    apb(1'b1, `SAC_IDX_CONVCTL, 8'h85);
    c = 0;
    while (front_sample !== 1'b1 && c < 100) begin
      @(posedge pclk);
      c++;
    end
    check("abort delay", 32'h1, {31'h0, c >= 2 * 8 && c <= 2 * 8 + 5});
    rdchk("kept high", `SAC_IDX_RESHI, 8'h01);
    rdchk("kept low", `SAC_IDX_RESLO, 8'h3a);
    rdchk("abort flag", `SAC_IDX_FLAGS, 8'h00);
    apb(1'b1, `SAC_IDX_CONVCTL, 8'h00);
    repeat (2) @(posedge pclk);
    check("powered off", 32'h0, {30'h0, front_power, front_sample});
    $display("test abort done");
    finish_test();
  end
endmodule
`default_nettype wire
